/* File: hw/link_pkg.sv */
package link_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // pixel clock silence before the serializer sleeps
  localparam int PCLK_STOP_NS = 1000;
  // serial stream silence before the deserializer drops lock
  localparam int STREAM_STOP_NS = 1000;
  // recovery loop lock time
  localparam int LOCK_NS = 10000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] PCLK_STOP_CYC =
    CNT_W'((PCLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STREAM_STOP_CYC =
    CNT_W'((STREAM_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LOCK_CYC =
    CNT_W'((LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int PIX_W = 14;
  localparam int FIFO_DEPTH = 16;
  localparam int GP_W = 4;
  localparam int GP_TWO = 2;
  localparam int GP_THREE = 3;
  localparam logic [PIX_W-1:0] SERIAL_IDLE = 14'h3FFF;

  // serializer strap: high level is the weak pulldown
  localparam logic SER_STRAP_PCLK = 1'h1;
  localparam logic SER_STRAP_OSC = 1'h0;
  // deserializer strap levels
  localparam logic [1:0] DES_STRAP_0R = 2'h0;
  localparam logic [1:0] DES_STRAP_3K = 2'h1;
  localparam logic [1:0] DES_STRAP_11K = 2'h2;

  // clock ratio times two
  localparam logic [2:0] RATIO_X2_DIV1 = 3'h2;
  localparam logic [2:0] RATIO_X2_DIV1P5 = 3'h3;
  localparam logic [2:0] RATIO_X2_DIV2 = 3'h4;

  typedef enum logic [1:0] {PM_12B_LOW, PM_12B_HIGH, PM_10B} payload_mode_t;
  typedef enum logic [1:0] {SER_OFF, SER_SLEEP, SER_RUN} ser_state_t;
  typedef enum logic [1:0] {DES_OFF, DES_SLEEP, DES_LOCKING, DES_LOCKED} des_state_t;

  typedef struct packed {
    logic ser_pdb;
    logic des_pdb;
    logic pclk;
    logic osc;
    logic serial_act;
    logic parallel_output_enable;
    logic oss;
    logic [GP_W-1:0] gp;
    logic ser_strap;
    logic [1:0] des_strap;
  } pins_t;
endpackage

/* File: hw/fifo_if.sv */
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8) ();
  logic [W-1:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  modport fifo(input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid);
  modport user(output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid);
endinterface

/* File: hw/sync_bits.sv */
`timescale 1ns/1ps
module sync_bits #(parameter int W = 1) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_state_t;
  sync_state_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.meta = d_i;
    next_s.q = s.meta;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;
endmodule

/* File: hw/pix_fifo.sv */
`timescale 1ns/1ps
module pix_fifo #(parameter int W = 8, parameter int DEPTH = 16) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } fifo_state_t;
  fifo_state_t s, next_s;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  assign push = q.wr_valid && !s.full;
  assign pop = q.rd_ready && !s.empty;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.full = (next_s.cnt == (AW+1)'(DEPTH));
    next_s.empty = (next_s.cnt == '0);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.empty <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[s.wp] <= q.wr_data;
    end
  end

  assign q.wr_ready = !s.full;
  assign q.rd_valid = !s.empty;
  assign q.rd_data = mem[s.rp];

  chk_fifo_count_bound: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
  chk_fifo_full_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (s.full && !q.rd_ready) |=> s.full && s.cnt == $past(s.cnt))
    else $error("full fifo accepted a word");
endmodule

/* File: hw/serdes_link_ctrl.sv */
`timescale 1ns/1ps
module serdes_link_ctrl import link_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ser_power_enable_n_pin_i,
  input wire logic des_power_enable_n_pin_i,
  input wire logic ser_mode_strap_i,
  input wire logic [1:0] des_mode_strap_i,
  input wire logic pclk_i,
  input wire logic ser_out_pin_three_i,
  output logic ser_out_pin_three_oen_n_o,
  output logic [GP_W-1:0] ser_gpo_o,
  input wire logic [GP_W-1:0] des_gp_pins_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  output logic [PIX_W-1:0] ser_word_o,
  output logic ser_word_valid_o,
  input wire logic ser_word_ready_i,
  output logic ser_asleep_o,
  output logic [1:0] ser_payload_mode_o,
  output logic ser_payload_valid_o,
  output logic [2:0] clk_ratio_x2_o,
  input wire logic serial_active_i,
  input wire logic [PIX_W-1:0] rx_word_i,
  input wire logic rx_valid_i,
  input wire logic parallel_output_enable_i,
  input wire logic output_state_sel_i,
  output logic lock_o,
  output logic lock_oen_n_o,
  output logic pass_o,
  output logic pass_oen_n_o,
  output logic [PIX_W-1:0] des_data_o,
  output logic des_pclk_o,
  output logic des_data_oen_n_o
);
  typedef struct packed {
    ser_state_t ser_state;
    logic ser_osc_mode;
    logic ser_pdb_d;
    logic des_pdb_d;
    logic pclk_d;
    logic osc_d;
    logic [CNT_W-1:0] ser_cnt;
    logic osc_div;
    logic [GP_W-1:0] gpo;
    logic ser_out_pin_three_oen_n;
    logic [PIX_W-1:0] word;
    logic word_valid;
    logic asleep;
    des_state_t des_state;
    payload_mode_t des_mode;
    logic [CNT_W-1:0] des_cnt;
    logic pay_valid;
    logic [2:0] ratio_x2;
    logic lock;
    logic lock_oen_n;
    logic pass;
    logic pass_oen_n;
    logic [PIX_W-1:0] dout;
    logic dpclk;
    logic dout_oen_n;
  } top_state_t;

  top_state_t s, next_s;
  pins_t pins_raw, p;
  logic pclk_edge, osc_edge, ser_rise, des_rise, rd_go, locked_n;

  fifo_if #(.W(PIX_W)) pix_q();

  function automatic payload_mode_t strap_mode(input logic [1:0] strap);
    payload_mode_t m;
    m = PM_10B;
    if (strap == DES_STRAP_0R) begin
      m = PM_12B_LOW;
    end else if (strap == DES_STRAP_3K) begin
      m = PM_12B_HIGH;
    end else if (strap == DES_STRAP_11K) begin
      m = PM_10B;
    end
    return m;
  endfunction

  assign pins_raw = '{ser_pdb: ser_power_enable_n_pin_i, des_pdb: des_power_enable_n_pin_i,
    pclk: pclk_i, osc: ser_out_pin_three_i, serial_act: serial_active_i,
    parallel_output_enable: parallel_output_enable_i, oss: output_state_sel_i, gp: des_gp_pins_i,
    ser_strap: ser_mode_strap_i, des_strap: des_mode_strap_i};

  sync_bits #(.W($bits(pins_t))) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(pins_raw),
    .q_o(p)
  );

  pix_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_pix_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .q(pix_q.fifo)
  );

  assign pclk_edge = p.pclk && !s.pclk_d;
  assign osc_edge = p.osc && !s.osc_d;
  assign ser_rise = p.ser_pdb && !s.ser_pdb_d;
  assign des_rise = p.des_pdb && !s.des_pdb_d;
  assign rd_go = (s.ser_state == SER_RUN) && p.ser_pdb && (!s.word_valid || ser_word_ready_i);
  assign pix_q.wr_data = pix_data_i;
  assign pix_q.wr_valid = pix_valid_i;
  assign pix_q.rd_ready = rd_go;

  always_comb begin
    next_s = s;
    locked_n = 1'b0;
    next_s.ser_pdb_d = p.ser_pdb;
    next_s.des_pdb_d = p.des_pdb;
    next_s.pclk_d = p.pclk;
    next_s.osc_d = p.osc;
    next_s.pay_valid = 1'b0;

    // serializer power and activity
    case (s.ser_state)
      SER_OFF: begin
        if (ser_rise) begin
          next_s.ser_osc_mode = (p.ser_strap == SER_STRAP_OSC);
          next_s.ser_state = SER_SLEEP;
          next_s.ser_cnt = '0;
        end
      end
      SER_SLEEP: begin
        if (pclk_edge) begin
          next_s.ser_state = SER_RUN;
          next_s.ser_cnt = '0;
        end
      end
      SER_RUN: begin
        if (pclk_edge) begin
          next_s.ser_cnt = '0;
        end else if (s.ser_cnt == PCLK_STOP_CYC - 1'b1) begin
          next_s.ser_state = SER_SLEEP;
        end else begin
          next_s.ser_cnt = s.ser_cnt + 1'b1;
        end
      end
      default: next_s.ser_state = SER_OFF;
    endcase
    if (!p.ser_pdb) begin
      next_s.ser_state = SER_OFF;
    end

    // serial word path
    if (next_s.ser_state != SER_RUN) begin
      next_s.word = SERIAL_IDLE;
      next_s.word_valid = 1'b0;
    end else if (rd_go) begin
      if (pix_q.rd_valid) begin
        next_s.word = pix_q.rd_data;
        next_s.word_valid = 1'b1;
      end else begin
        next_s.word_valid = 1'b0;
      end
    end

    next_s.asleep = (next_s.ser_state != SER_RUN);
    // oscillator divider and general outputs
    if (next_s.ser_state == SER_OFF) begin
      next_s.osc_div = 1'b0;
      next_s.gpo = '0;
    end else begin
      if (next_s.ser_osc_mode && osc_edge) begin
        next_s.osc_div = !s.osc_div;
      end
      next_s.gpo = p.gp;
      if (next_s.ser_osc_mode) begin
        next_s.gpo[GP_TWO] = next_s.osc_div;
        next_s.gpo[GP_THREE] = 1'b0;
      end
    end
    next_s.ser_out_pin_three_oen_n = next_s.ser_osc_mode || (next_s.ser_state == SER_OFF);

    // deserializer lock sequence
    case (s.des_state)
      DES_OFF: begin
        if (des_rise) begin
          next_s.des_mode = strap_mode(p.des_strap);
          next_s.des_state = DES_LOCKING;
          next_s.des_cnt = '0;
        end
      end
      DES_SLEEP: begin
        if (p.serial_act) begin
          next_s.des_state = DES_LOCKING;
          next_s.des_cnt = '0;
        end
      end
      DES_LOCKING: begin
        if (!p.serial_act) begin
          next_s.des_state = DES_SLEEP;
        end else if (s.des_cnt == LOCK_CYC - 1'b1) begin
          next_s.des_state = DES_LOCKED;
          next_s.des_cnt = '0;
          next_s.pay_valid = 1'b1;
        end else begin
          next_s.des_cnt = s.des_cnt + 1'b1;
        end
      end
      DES_LOCKED: begin
        if (p.serial_act) begin
          next_s.des_cnt = '0;
        end else if (s.des_cnt == STREAM_STOP_CYC - 1'b1) begin
          next_s.des_state = DES_SLEEP;
        end else begin
          next_s.des_cnt = s.des_cnt + 1'b1;
        end
      end
      default: next_s.des_state = DES_OFF;
    endcase
    if (!p.des_pdb) begin
      next_s.des_state = DES_OFF;
      next_s.pay_valid = 1'b0;
    end

    case (next_s.des_mode)
      PM_12B_LOW: next_s.ratio_x2 = RATIO_X2_DIV1;
      PM_12B_HIGH: next_s.ratio_x2 = RATIO_X2_DIV1P5;
      default: next_s.ratio_x2 = RATIO_X2_DIV2;
    endcase

    // deserializer output states
    locked_n = (next_s.des_state == DES_LOCKED);
    if (!p.des_pdb) begin
      next_s.lock = 1'b0;
      next_s.lock_oen_n = 1'b1;
      next_s.pass = 1'b0;
      next_s.pass_oen_n = 1'b1;
      next_s.dout = '0;
      next_s.dpclk = 1'b0;
      next_s.dout_oen_n = 1'b1;
    end else begin
      next_s.lock = locked_n;
      next_s.lock_oen_n = 1'b0;
      if (p.oss && !p.parallel_output_enable) begin
        next_s.pass_oen_n = 1'b1;
        next_s.dout_oen_n = 1'b1;
        next_s.pass = 1'b0;
        next_s.dout = '0;
        next_s.dpclk = 1'b0;
      end else if (locked_n && p.parallel_output_enable && p.oss) begin
        next_s.pass_oen_n = 1'b0;
        next_s.dout_oen_n = 1'b0;
        next_s.pass = 1'b1;
        if (rx_valid_i) begin
          next_s.dout = rx_word_i;
          next_s.dpclk = !s.dpclk;
        end
      end else if (!locked_n && p.parallel_output_enable && p.oss) begin
        next_s.pass_oen_n = 1'b0;
        next_s.dout_oen_n = 1'b0;
      end else begin
        next_s.pass_oen_n = 1'b0;
        next_s.dout_oen_n = 1'b0;
        next_s.pass = 1'b0;
        next_s.dout = '0;
        next_s.dpclk = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.ser_out_pin_three_oen_n <= 1'b1;
      s.word <= SERIAL_IDLE;
      s.asleep <= 1'b1;
      s.lock_oen_n <= 1'b1;
      s.pass_oen_n <= 1'b1;
      s.dout_oen_n <= 1'b1;
      s.ratio_x2 <= RATIO_X2_DIV1;
    end else begin
      s <= next_s;
    end
  end

  assign ser_out_pin_three_oen_n_o = s.ser_out_pin_three_oen_n;
  assign ser_gpo_o = s.gpo;
  assign pix_ready_o = pix_q.wr_ready;
  assign ser_word_o = s.word;
  assign ser_word_valid_o = s.word_valid;
  assign ser_asleep_o = s.asleep;
  assign ser_payload_mode_o = s.des_mode;
  assign ser_payload_valid_o = s.pay_valid;
  assign clk_ratio_x2_o = s.ratio_x2;
  assign lock_o = s.lock;
  assign lock_oen_n_o = s.lock_oen_n;
  assign pass_o = s.pass;
  assign pass_oen_n_o = s.pass_oen_n;
  assign des_data_o = s.dout;
  assign des_pclk_o = s.dpclk;
  assign des_data_oen_n_o = s.dout_oen_n;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence des_wake;
    s.des_state == DES_OFF && des_rise;
  endsequence
  sequence pclk_quiet;
    s.ser_state == SER_RUN && s.ser_cnt == PCLK_STOP_CYC - 1'b1 && !pclk_edge && p.ser_pdb;
  endsequence
  sequence stream_gone;
    s.des_state == DES_LOCKED && s.des_cnt == STREAM_STOP_CYC - 1'b1 && !p.serial_act;
  endsequence

  chk_osc_pin_input: assert property (s.ser_osc_mode |-> s.ser_out_pin_three_oen_n)
    else $error("pin three driven in oscillator mode");
  chk_div_two_toggle: assert property ((s.ser_osc_mode && s.ser_state != SER_OFF
    && p.ser_pdb && osc_edge) |=> s.osc_div != $past(s.osc_div)
    && s.gpo[GP_TWO] == s.osc_div)
    else $error("divided clock missed an oscillator edge");
  chk_gpo_blocked: assert property ((s.ser_osc_mode && s.ser_state != SER_OFF)
    |-> s.gpo[GP_THREE] == 1'b0 && s.gpo[GP_TWO] == s.osc_div)
    else $error("remote pin forwarded in oscillator mode");
  chk_gpo_forward: assert property ((!s.ser_osc_mode && s.ser_state != SER_OFF && p.ser_pdb)
    |=> s.gpo == $past(p.gp))
    else $error("remote pins not forwarded");
  chk_pclk_sleep: assert property (pclk_quiet |=> s.ser_state == SER_SLEEP
    ##0 s.word == SERIAL_IDLE)
    else $error("serializer did not sleep on pclk stop");
  chk_sleep_static: assert property (s.ser_state != SER_RUN
    |-> s.word == SERIAL_IDLE && !s.word_valid)
    else $error("serial output not static high while asleep");
  chk_lock_wait: assert property (des_wake ##1 p.serial_act [*8] |-> !s.lock)
    else $error("lock asserted too early");
  chk_lock_done: assert property ($rose(s.des_state == DES_LOCKED)
    |-> s.lock && s.pay_valid && $past(s.des_cnt) == LOCK_CYC - 1'b1)
    else $error("lock end not signalled");
  chk_lock_loss: assert property (stream_gone ##0 p.des_pdb |=> !s.lock
    && s.des_state == DES_SLEEP)
    else $error("lock kept after stream loss");
  chk_pdb_off: assert property (!p.des_pdb |=> s.lock_oen_n && s.pass_oen_n
    && s.dout_oen_n)
    else $error("outputs driven in powerdown");
  chk_sleep_state: assert property ((s.des_state == DES_SLEEP && p.des_pdb
    && p.oss && !p.parallel_output_enable) |=> s.dout_oen_n || $past(s.des_state) != DES_SLEEP)
    else $error("sleep outputs ignore state select");
  chk_mode_kept: assert property ((s.des_state != DES_OFF && p.des_pdb)
    |=> $stable(s.des_mode))
    else $error("payload mode changed while powered");
  chk_mode_ratio: assert property (des_wake ##1 (s.des_mode == PM_10B)
    |-> s.ratio_x2 == RATIO_X2_DIV2)
    else $error("clock ratio wrong for mode");
endmodule

/* File: test/imager_model.sv */
`timescale 1ns/1ps
module imager_model import link_pkg::*; #(parameter logic [PIX_W-1:0] WORD0 = 14'h0100) (
  input wire logic sys_clk_i,
  input wire logic pclk_en_i,
  input wire logic send_i,
  input wire logic pix_ready_i,
  output logic pclk_o,
  output logic [PIX_W-1:0] pix_data_o,
  output logic pix_valid_o,
  output int sent_o
);
  logic [1:0] div;
  logic took;
  initial begin
    div = 2'h0;
    pclk_o = 1'b0;
    pix_valid_o = 1'b0;
    pix_data_o = WORD0;
    sent_o = 0;
  end
  // own oscillator assumed, pixel clock stands still when stopped
  always @(posedge sys_clk_i) begin
    took = pix_valid_o && pix_ready_i;
    #5;
    if (pclk_en_i) begin
      div = div + 2'h1;
      pclk_o = div[1];
    end
    if (took) begin
      sent_o++;
    end
    // a pending word is held until taken
    if (send_i || (pix_valid_o && !took)) begin
      pix_valid_o = 1'b1;
      pix_data_o = WORD0 + PIX_W'(sent_o);
    end else begin
      pix_valid_o = 1'b0;
      pix_data_o = ~pix_data_o;
    end
  end
endmodule

/* File: test/test_serdes_link_ctrl.sv */
`timescale 1ns/1ps
module test_serdes_link_ctrl;
  import link_pkg::*;
  localparam logic [PIX_W-1:0] WORD0 = 14'h0100;
  localparam logic [1:0] STRAPS [3] = '{DES_STRAP_0R, DES_STRAP_3K, DES_STRAP_11K};
  localparam logic [1:0] PMODE [3] = '{PM_12B_LOW, PM_12B_HIGH, PM_10B};
  localparam logic [2:0] RATIO [3] = '{RATIO_X2_DIV1, RATIO_X2_DIV1P5, RATIO_X2_DIV2};
  logic sys_clk_i = 1'b0;
  logic rstn_i, ser_pdb, des_pdb, ser_strap, osc, serial_active_i, rx_valid_i, parallel_output_enable, oss;
  logic ser_word_ready_i, pclk_en, send, pix_valid_i, pclk_i, pin3, mon, g2, p;
  logic [1:0] des_strap;
  logic [GP_W-1:0] des_gp, ser_gpo_o;
  logic [PIX_W-1:0] pix_data_i, rx_word_i, ser_word_o, des_data_o;
  logic ser_out_pin_three_oen_n_o, pix_ready_o, ser_word_valid_o, ser_asleep_o;
  logic ser_payload_valid_o, lock_o, lock_oen_n_o, pass_o, pass_oen_n_o, des_pclk_o;
  logic des_data_oen_n_o;
  logic [1:0] ser_payload_mode_o;
  logic [2:0] clk_ratio_x2_o;
  int err_count, tests_run, sent, rcvd, toggles;

  always #25 sys_clk_i = ~sys_clk_i;
  // pin three wire level
  assign pin3 = (ser_out_pin_three_oen_n_o === 1'b0) ? ser_gpo_o[3] : osc;

  serdes_link_ctrl u_dut (.sys_clk_i, .rstn_i, .ser_power_enable_n_pin_i(ser_pdb),
    .des_power_enable_n_pin_i(des_pdb), .ser_mode_strap_i(ser_strap),
    .des_mode_strap_i(des_strap), .pclk_i, .ser_out_pin_three_i(pin3),
    .ser_out_pin_three_oen_n_o, .ser_gpo_o, .des_gp_pins_i(des_gp), .pix_data_i,
    .pix_valid_i, .pix_ready_o, .ser_word_o, .ser_word_valid_o, .ser_word_ready_i,
    .ser_asleep_o, .ser_payload_mode_o, .ser_payload_valid_o, .clk_ratio_x2_o,
    .serial_active_i, .rx_word_i, .rx_valid_i, .parallel_output_enable_i(parallel_output_enable),
    .output_state_sel_i(oss), .lock_o, .lock_oen_n_o, .pass_o, .pass_oen_n_o,
    .des_data_o, .des_pclk_o, .des_data_oen_n_o);

  imager_model #(.WORD0(WORD0)) u_img (.sys_clk_i, .pclk_en_i(pclk_en), .send_i(send),
    .pix_ready_i(pix_ready_o), .pclk_o(pclk_i), .pix_data_o(pix_data_i),
    .pix_valid_o(pix_valid_i), .sent_o(sent));

  task step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #5;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // stream order and divider edge count
  always @(posedge sys_clk_i) begin
    if (ser_word_valid_o === 1'b1 && ser_word_ready_i === 1'b1) begin
      check(16'(ser_word_o), 16'(WORD0 + PIX_W'(rcvd)));
      rcvd++;
    end
    if (mon && ser_gpo_o[2] !== g2) begin
      toggles++;
    end
    g2 = ser_gpo_o[2];
  end

  task cyc_ser;
    ser_pdb = 1'b0;
    step(4);
    ser_pdb = 1'b1;
    step(4);
  endtask

  task wait_lock(output int n);
    n = 0;
    while (lock_o !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
  endtask

  task t_reset;
    check(ser_out_pin_three_oen_n_o, 1);
    check(lock_oen_n_o, 1);
    check(des_data_oen_n_o, 1);
    check(pass_oen_n_o, 1);
    check(ser_word_o, SERIAL_IDLE);
    check(ser_asleep_o, 1);
  endtask

  task t_gpo;
    des_gp = 4'hA;
    ser_strap = SER_STRAP_PCLK;
    cyc_ser;
    check(ser_gpo_o, 4'hA);
    check(ser_out_pin_three_oen_n_o, 0);
    des_gp = 4'hF;
    ser_strap = SER_STRAP_OSC;
    cyc_ser;
    check(ser_out_pin_three_oen_n_o, 1);
    check(ser_gpo_o[3], 0);
    check(ser_gpo_o[1:0], 2'h3);
    mon = 1'b1;
    repeat (8) begin
      osc = 1'b1;
      step(4);
      osc = 1'b0;
      step(4);
    end
    step(6);
    mon = 1'b0;
    check(16'(toggles), 16'h0008);
    ser_strap = SER_STRAP_PCLK;
    cyc_ser;
  endtask

  task t_modes;
    int n;
    for (int s = 0; s < 3; s++) begin
      des_pdb = 1'b0;
      des_strap = STRAPS[s];
      step(4);
      des_pdb = 1'b1;
      wait_lock(n);
      check(16'(n >= 200 && n <= 206), 1);
      check(ser_payload_valid_o, 1);
      check(ser_payload_mode_o, PMODE[s]);
      check(clk_ratio_x2_o, RATIO[s]);
      des_strap = STRAPS[(s + 1) % 3];
      step(5);
      check(ser_payload_valid_o, 0);
      check(ser_payload_mode_o, PMODE[s]);
      check(clk_ratio_x2_o, RATIO[s]);
    end
  endtask

  task t_output;
    int n;
    p = des_pclk_o;
    rx_word_i = 14'h2A5;
    rx_valid_i = 1'b1;
    step(1);
    rx_valid_i = 1'b0;
    step(4);
    check(des_data_o, 14'h2A5);
    check(des_pclk_o, !p);
    check(des_data_oen_n_o, 0);
    check(pass_o, 1);
    check(lock_oen_n_o, 0);
    parallel_output_enable = 1'b0;
    step(5);
    check(des_data_oen_n_o, 1);
    check(pass_oen_n_o, 1);
    parallel_output_enable = 1'b1;
    oss = 1'b0;
    step(5);
    check(des_data_oen_n_o, 0);
    check(des_data_o, 14'h0000);
    check(pass_o, 0);
    oss = 1'b1;
    step(5);
    rx_word_i = 14'h15A;
    rx_valid_i = 1'b1;
    step(1);
    rx_valid_i = 1'b0;
    step(4);
    check(des_data_o, 14'h15A);
    serial_active_i = 1'b0;
    step(30);
    check(lock_o, 0);
    check(lock_oen_n_o, 0);
    check(des_data_oen_n_o, 0);
    check(des_data_o, 14'h15A);
    parallel_output_enable = 1'b0;
    step(5);
    check(des_data_oen_n_o, 1);
    parallel_output_enable = 1'b1;
    step(5);
    check(des_data_oen_n_o, 0);
    serial_active_i = 1'b1;
    wait_lock(n);
    check(16'(n <= 210), 1);
    des_pdb = 1'b0;
    step(5);
    check(lock_oen_n_o, 1);
    check(des_data_oen_n_o, 1);
  endtask

  task t_sleep;
    pclk_en = 1'b0;
    step(30);
    check(ser_asleep_o, 1);
    check(ser_word_o, SERIAL_IDLE);
    check(ser_word_valid_o, 0);
    pclk_en = 1'b1;
    step(12);
    check(ser_asleep_o, 0);
    ser_pdb = 1'b0;
    step(5);
    check(ser_asleep_o, 1);
    ser_pdb = 1'b1;
    step(30);
  endtask

  task t_fifo;
    int w;
    ser_word_ready_i = 1'b0;
    send = 1'b1;
    w = 0;
    while (pix_ready_o !== 1'b0 && w < 100) begin
      step(1);
      w++;
    end
    send = 1'b0;
    step(3);
    check(pix_ready_o, 0);
    check(16'(sent >= FIFO_DEPTH && sent <= FIFO_DEPTH + 1), 1);
    // drain with the far side stalling every other cycle
    for (int i = 0; i < 120; i++) begin
      ser_word_ready_i = i[0];
      step(1);
    end
    check(16'(rcvd), 16'(sent));
    check(pix_ready_o, 1);
  endtask

  initial begin
    #(5000 * 50);
    err_count++;
    final_report;
  end

  initial begin
    rstn_i = 1'b0;
    ser_pdb = 1'b0;
    des_pdb = 1'b0;
    ser_strap = SER_STRAP_PCLK;
    des_strap = DES_STRAP_0R;
    osc = 1'b0;
    serial_active_i = 1'b1;
    rx_valid_i = 1'b0;
    rx_word_i = 14'h0000;
    parallel_output_enable = 1'b1;
    oss = 1'b1;
    ser_word_ready_i = 1'b1;
    pclk_en = 1'b1;
    send = 1'b0;
    des_gp = 4'h0;
    mon = 1'b0;
    g2 = 1'b0;
    err_count = 0;
    tests_run = 0;
    rcvd = 0;
    toggles = 0;
    step(16);
    rstn_i = 1'b1;
    step(1);
    t_reset;
    t_gpo;
    t_modes;
    t_output;
    t_sleep;
    t_fifo;
    final_report;
  end
endmodule
